// ===== usu_defines.vh
`ifndef USU_DEFINES_VH
`define USU_DEFINES_VH
// wire mode codes
`define USU_WM_OFF 2'h0
`define USU_WM_THREE 2'h1
`define USU_WM_TWO 2'h2
`define USU_WM_TWO_OVF 2'h3
// shift register msb
`define USU_MSB 7
// counter wrap value
`define USU_CNT_MAX 4'hF
`define USU_CNT_ZERO 4'h0
// buffer depth
`define USU_BUF_DEPTH 2
`endif

// ===== usu_buf2.v
`timescale 1ns/10ps
// two-entry buffer for received bytes
module usu_buf2 (
  input wire clk,
  input wire rst_b,
  input wire [7:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output wire [7:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [7:0] mem_r [0:1]; // storage
  reg wp_r; // write index
  reg rp_r; // read index
  reg [1:0] cnt_r; // fill level
  reg [7:0] head_r; // registered head word
  reg head_v_r; // registered head valid
  wire push;
  wire pop;
  wire rp_nxt; // read index after this edge
  wire [1:0] cnt_nxt; // fill level after this edge
  assign in_ready = (cnt_r != 2'h2);
  // outputs straight from flops
  assign out_valid = head_v_r;
  assign out_data = head_r;
  assign push = in_valid & in_ready;
  assign pop = head_v_r & out_ready;
  assign rp_nxt = rp_r ^ pop;
  assign cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
  // pointer, level and head update
  always @(posedge clk) begin
    if (!rst_b) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
      head_v_r <= 1'b0;
      head_r <= 8'h00;
    end else begin
      if (push) begin
        mem_r[wp_r] <= in_data;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt_r <= cnt_nxt;
      head_v_r <= (cnt_nxt != 2'h0);
      // word landing in the new head slot bypasses storage
      if (push & (wp_r == rp_nxt)) begin
        head_r <= in_data;
      end else begin
        head_r <= mem_r[rp_nxt];
      end
    end
  end
endmodule // usu_buf2

// ===== usu_pins.v
`timescale 1ns/10ps
`include "usu_defines.vh"
// What this block does
// - mode changes outputs only, inputs always work
// - mode 00 disables outputs, hold, start detect
// - three-wire: shift data replaces port output value
// - three-wire input pin: pull-up from port bit
// - data-in and clock pins keep port behaviour
// - two-wire: open-collector, enabled by direction bit
// - sda low when shift msb or port zero
// - scl low when port zero or start hold
// - start condition holds scl until flag cleared
// - two-wire: inputs unchanged, pull-ups forced off
// - mode 11 also holds scl after overflow
// - start detector active only in two-wire modes
// - serial output comes from shift msb latch
// - overflow flag set on 15 to 0 wrap
// - start flag cleared by writing one only
module usu_pins (
  input wire clk,
  input wire rst_b,
  input wire [1:0] wire_mode_select, // mode field from control
  input wire mode_wr, // load mode field
  // port registers of the three pins
  input wire do_port_bit,
  input wire do_dir_bit,
  input wire sda_port_bit,
  input wire sda_dir_bit,
  input wire scl_port_bit,
  input wire scl_dir_bit,
  // shift register side
  input wire [7:0] shift_data, // shift register contents
  input wire shift_clk_stb, // one-cycle shift strobe
  input wire latch_open, // output latch transparent
  input wire cnt_wrap_stb, // counter step strobe
  input wire [3:0] cnt_value, // counter value before step
  input wire clr_start_flag, // write one to start flag
  input wire clr_ovf_flag, // write one to overflow flag
  // raw pins from outside
  input wire serial_data_in_pin,
  input wire serial_clock_pin,
  // pin drivers
  output reg do_out,
  output reg do_oe,
  output reg do_pullup,
  output reg sda_out,
  output reg sda_oe,
  output reg sda_pullup_off,
  output reg scl_out,
  output reg scl_oe,
  output reg scl_pullup_off,
  // status
  output reg start_condition_flag,
  output reg counter_overflow_flag,
  output reg [1:0] mode_out,
  // synchronised inputs to shift logic
  output reg data_in_sync,
  output reg clk_in_sync,
  output reg clk_rise,
  output reg clk_fall,
  // received byte stream
  input wire rx_push,
  output reg rx_ready,
  output wire [7:0] rx_data,
  output wire rx_valid,
  input wire rx_take
);
  // mode states one-hot
  localparam ST_OFF = 4'h1;
  localparam ST_THREE = 4'h2;
  localparam ST_TWO = 4'h4;
  localparam ST_TWO_OVF = 4'h8;
  reg [3:0] st_r; // current mode
  reg [3:0] st_nxt;
  reg [1:0] sd_r; // data synchroniser
  reg [1:0] sc_r; // clock synchroniser
  reg sd_d_r; // delayed sda for start detect
  reg sc_d_r; // delayed scl
  reg msb_latch_r; // output latch
  reg start_hold_r; // start hold
  reg ovf_hold_r; // overflow hold
  wire two_wire;
  wire start_seen;
  wire ovf_seen;
  wire buf_in_ready;
  // decode mode code to state
  function [3:0] dec_mode;
    input [1:0] m;
    begin
      case (m)
        `USU_WM_THREE: dec_mode = ST_THREE;
        `USU_WM_TWO: dec_mode = ST_TWO;
        `USU_WM_TWO_OVF: dec_mode = ST_TWO_OVF;
        default: dec_mode = ST_OFF;
      endcase
    end
  endfunction
  // next mode
  always @* begin
    st_nxt = st_r;
    if (mode_wr) begin
      st_nxt = dec_mode(wire_mode_select);
    end
  end
  // mode register
  always @(posedge clk) begin
    if (!rst_b) begin
      st_r <= ST_OFF;
    end else begin
      st_r <= st_nxt;
    end
  end
  assign two_wire = st_r[2] | st_r[3];
  // input synchronisers, active in every mode
  always @(posedge clk) begin
    if (!rst_b) begin
      sd_r <= 2'h3;
      sc_r <= 2'h3;
      sd_d_r <= 1'b1;
      sc_d_r <= 1'b1;
    end else begin
      sd_r <= {sd_r[0], serial_data_in_pin};
      sc_r <= {sc_r[0], serial_clock_pin};
      sd_d_r <= sd_r[1];
      sc_d_r <= sc_r[1];
    end
  end
  // sda falling while scl high
  assign start_seen = two_wire & sd_d_r & ~sd_r[1] & sc_r[1] & sc_d_r;
  assign ovf_seen = cnt_wrap_stb & (cnt_value == `USU_CNT_MAX);
  // output latch from shift msb
  always @(posedge clk) begin
    if (!rst_b) begin
      msb_latch_r <= 1'b1;
    end else if (latch_open | shift_clk_stb) begin
      msb_latch_r <= shift_data[`USU_MSB];
    end
  end
  // flags and holds, set wins over clear
  always @(posedge clk) begin
    if (!rst_b) begin
      start_condition_flag <= 1'b0;
      counter_overflow_flag <= 1'b0;
      start_hold_r <= 1'b0;
      ovf_hold_r <= 1'b0;
    end else begin
      if (start_seen) begin
        start_condition_flag <= 1'b1;
      end else if (clr_start_flag) begin
        start_condition_flag <= 1'b0;
      end
      if (ovf_seen) begin
        counter_overflow_flag <= 1'b1;
      end else if (clr_ovf_flag) begin
        counter_overflow_flag <= 1'b0;
      end
      if (start_seen & scl_dir_bit) begin
        start_hold_r <= 1'b1;
      end else if (clr_start_flag | ~two_wire) begin
        start_hold_r <= 1'b0;
      end
      if (ovf_seen & st_r[3]) begin
        ovf_hold_r <= 1'b1;
      end else if (clr_ovf_flag | ~st_r[3]) begin
        ovf_hold_r <= 1'b0;
      end
    end
  end
  // pin driver registers
  always @(posedge clk) begin
    if (!rst_b) begin
      do_out <= 1'b0;
      do_oe <= 1'b0;
      do_pullup <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      sda_pullup_off <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
      scl_pullup_off <= 1'b0;
    end else begin
      case (st_r)
        ST_THREE: begin
          do_out <= msb_latch_r;
          do_oe <= do_dir_bit;
          do_pullup <= ~do_dir_bit & do_port_bit;
          sda_out <= sda_port_bit;
          sda_oe <= sda_dir_bit;
          sda_pullup_off <= 1'b0;
          scl_out <= scl_port_bit;
          scl_oe <= scl_dir_bit;
          scl_pullup_off <= 1'b0;
        end
        ST_TWO, ST_TWO_OVF: begin
          do_out <= do_port_bit;
          do_oe <= do_dir_bit;
          do_pullup <= ~do_dir_bit & do_port_bit;
          sda_out <= 1'b0;
          sda_oe <= sda_dir_bit & (~msb_latch_r | ~sda_port_bit);
          sda_pullup_off <= 1'b1;
          scl_out <= 1'b0;
          scl_oe <= scl_dir_bit & (~scl_port_bit | start_hold_r | ovf_hold_r);
          scl_pullup_off <= 1'b1;
        end
        default: begin
          do_out <= do_port_bit;
          do_oe <= do_dir_bit;
          do_pullup <= ~do_dir_bit & do_port_bit;
          sda_out <= sda_port_bit;
          sda_oe <= sda_dir_bit;
          sda_pullup_off <= 1'b0;
          scl_out <= scl_port_bit;
          scl_oe <= scl_dir_bit;
          scl_pullup_off <= 1'b0;
        end
      endcase
    end
  end
  // status and synchronised inputs out
  always @(posedge clk) begin
    if (!rst_b) begin
      mode_out <= `USU_WM_OFF;
      data_in_sync <= 1'b1;
      clk_in_sync <= 1'b1;
      clk_rise <= 1'b0;
      clk_fall <= 1'b0;
      rx_ready <= 1'b0;
    end else begin
      mode_out <= {two_wire, st_r[1] | st_r[3]};
      data_in_sync <= sd_r[1];
      clk_in_sync <= sc_r[1];
      clk_rise <= sc_r[1] & ~sc_d_r;
      clk_fall <= ~sc_r[1] & sc_d_r;
      rx_ready <= buf_in_ready;
    end
  end
  // received byte buffer
  usu_buf2 u_buf (
    .clk(clk),
    .rst_b(rst_b),
    .in_data(shift_data),
    .in_valid(rx_push),
    .in_ready(buf_in_ready),
    .out_data(rx_data),
    .out_valid(rx_valid),
    .out_ready(rx_take)
  );
endmodule // usu_pins

// ===== usu_pins_assertions.sv
`timescale 1ns/10ps
// watches pin enables and flags per wire mode
module usu_chk (
  input wire clk,
  input wire rst_b,
  input wire do_dir_bit,
  input wire do_port_bit,
  input wire scl_dir_bit,
  input wire scl_port_bit,
  input wire cnt_wrap_stb,
  input wire [3:0] cnt_value,
  input wire clr_start_flag,
  input wire do_oe,
  input wire do_pullup,
  input wire sda_pullup_off,
  input wire scl_pullup_off,
  input wire scl_oe,
  input wire start_condition_flag,
  input wire counter_overflow_flag,
  input wire [1:0] mode_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // mode stable over two edges, so outputs reflect it
  sequence s_three; (mode_out == 2'h1) [*2]; endsequence
  sequence s_two; mode_out[1] [*2]; endsequence
  sequence s_ovh; (counter_overflow_flag && mode_out == 2'h3) [*2]; endsequence
  property p_three; s_three |-> do_oe == $past(do_dir_bit); endproperty
  a_three: assert property (p_three) else $error("do enable wrong");
  property p_pu; s_three |-> do_pullup == $past(!do_dir_bit && do_port_bit); endproperty
  a_pu: assert property (p_pu) else $error("do pull-up wrong");
  property p_two; s_two |-> sda_pullup_off && scl_pullup_off; endproperty
  a_two: assert property (p_two) else $error("pull-ups not off");
  property p_scl; s_two ##0 $past(scl_dir_bit && !scl_port_bit) |-> scl_oe; endproperty
  a_scl: assert property (p_scl) else $error("scl not pulled");
  property p_sf; $rose(start_condition_flag) |-> mode_out[1]; endproperty
  a_sf: assert property (p_sf) else $error("start seen off mode");
  property p_sc; $fell(start_condition_flag) |-> $past(clr_start_flag); endproperty
  a_sc: assert property (p_sc) else $error("start flag lost");
  property p_ovs; cnt_wrap_stb && cnt_value == 4'hF |=> counter_overflow_flag; endproperty
  a_ovs: assert property (p_ovs) else $error("overflow not set");
  property p_ovh; s_ovh ##0 $past(scl_dir_bit) |-> scl_oe; endproperty
  a_ovh: assert property (p_ovh) else $error("overflow hold off");
endmodule // usu_chk

// ===== usu_peer.sv
`timescale 1ns/10ps
// far-side bus peer; drives both lines high when idle
module usu_peer (
  output logic scl,
  output logic sda
);
  initial begin
    scl = 1'h1;
    sda = 1'h1;
  end
  // start, eight bits msb first, stop; clock runs only inside
  task automatic frame(input logic [7:0] b);
    sda = 1'h0; // falls while clock high
    #24 scl = 1'h0;
    for (int i = 7; i >= 0; i--) begin
      sda = b[i]; // change only while clock low
      #24 scl = 1'h1;
      #24 scl = 1'h0;
    end
    sda = 1'h0;
    #24 scl = 1'h1;
    #24 sda = 1'h1; // stop
  endtask
endmodule // usu_peer

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic mode_wr = 1'h0;
  logic [1:0] sel = 2'h0;
  logic do_p = 1'h0, do_d = 1'h0, sda_p = 1'h1, sda_d = 1'h0, scl_p = 1'h1, scl_d = 1'h0;
  logic cnt_stb = 1'h0, clr_sf = 1'h0, clr_of = 1'h0, push = 1'h0, take = 1'h0;
  logic [7:0] sh = 8'h00;
  logic lo = 1'h1;
  logic ss = 1'h0;
  wire d_s, c_s, c_f;
  int nf = 0;
  logic [3:0] cnt = 4'h0;
  wire do_out, do_oe, do_pu, sda_out, sda_oe, sda_puo, scl_out, scl_oe, scl_puo, sf, of, c_r, rx_rdy, rx_v;
  wire [1:0] mode;
  wire [7:0] rx_d;
  wire p_scl, p_sda;
  int error_cnt = 0;
  int checks = 0;
  int n = 0;
  // open-drain wires: low if either party pulls
  wire sda_w = p_sda & ~(sda_oe & ~sda_out);
  wire scl_w = p_scl & ~(scl_oe & ~scl_out);
  always #2.5 clk = ~clk;
  // counts synced clock rises
  always @(posedge clk) if (c_r === 1'h1) n <= n + 1;
  // counts synced clock falls
  always @(posedge clk) if (c_f === 1'h1) nf <= nf + 1;
  usu_peer u_peer (.scl(p_scl), .sda(p_sda));
  usu_pins DUT (.clk, .rst_b, .wire_mode_select(sel), .mode_wr, .do_port_bit(do_p), .do_dir_bit(do_d),
    .sda_port_bit(sda_p), .sda_dir_bit(sda_d), .scl_port_bit(scl_p), .scl_dir_bit(scl_d), .shift_data(sh),
    .shift_clk_stb(ss), .latch_open(lo), .cnt_wrap_stb(cnt_stb), .cnt_value(cnt), .clr_start_flag(clr_sf),
    .clr_ovf_flag(clr_of), .serial_data_in_pin(sda_w), .serial_clock_pin(scl_w), .do_out, .do_oe,
    .do_pullup(do_pu), .sda_out, .sda_oe, .sda_pullup_off(sda_puo), .scl_out, .scl_oe, .scl_pullup_off(scl_puo),
    .start_condition_flag(sf), .counter_overflow_flag(of), .mode_out(mode), .data_in_sync(d_s), .clk_in_sync(c_s),
    .clk_rise(c_r), .clk_fall(c_f), .rx_push(push), .rx_ready(rx_rdy), .rx_data(rx_d), .rx_valid(rx_v),
    .rx_take(take));
  task step(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task cmp(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task close_out;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one-cycle mode load, then outputs settle
  task setm(input logic [1:0] m);
    @(posedge clk);
    sel <= m;
    mode_wr <= 1'h1;
    @(posedge clk) mode_wr <= 1'h0;
    step(3);
  endtask
  task t_off;
    cmp({mode, sf, of, scl_oe}, 9'h000);
    n = 0;
    nf = 0;
    u_peer.frame(8'hA5);
    step(4);
    cmp(n, 9'h009);
    cmp(nf, 9'h009);
    cmp({d_s, c_s}, 9'h003);
    cmp({sf, scl_oe}, 9'h000);
    $display("t_off done");
  endtask
  task t_3w;
    setm(2'h1);
    @(posedge clk);
    {do_d, do_p} <= 2'h1;
    sh <= 8'h80;
    step(4);
    cmp({do_oe, do_pu}, 9'h001);
    @(posedge clk) {do_d, do_p} <= 2'h2;
    step(4);
    cmp({do_oe, do_out}, 9'h003);
    // closed latch holds the old msb until a shift strobe
    @(posedge clk) lo <= 1'h0;
    sh <= 8'h00;
    step(4);
    cmp(do_out, 9'h001);
    @(posedge clk) ss <= 1'h1;
    @(posedge clk) ss <= 1'h0;
    lo <= 1'h1;
    step(3);
    cmp(do_out, 9'h000);
    $display("t_3w done");
  endtask
  task t_2w;
    setm(2'h2);
    cmp({mode, sda_puo, scl_puo}, 9'h00B);
    @(posedge clk) {sda_d, sda_p, scl_d, scl_p} <= 4'hA;
    step(4);
    cmp({sda_oe, sda_out, scl_oe, scl_out}, 9'h00A);
    @(posedge clk) {sda_p, scl_p} <= 2'h3;
    sh <= 8'h00;
    step(4);
    cmp({sda_oe, scl_oe}, 9'h002);
    @(posedge clk) sh <= 8'h80;
    step(4);
    cmp({sda_oe, scl_oe}, 9'h000);
    u_peer.frame(8'h3C);
    step(4);
    cmp({sf, scl_oe, scl_out, c_s, d_s}, 9'h019);
    @(posedge clk) clr_sf <= 1'h1;
    @(posedge clk) clr_sf <= 1'h0;
    step(3);
    cmp({sf, scl_oe}, 9'h000);
    $display("t_2w done");
  endtask
  // step at E must not flag, step at F must
  task t_ovf(input logic [1:0] m);
    setm(m);
    @(posedge clk);
    cnt <= 4'hE;
    cnt_stb <= 1'h1;
    @(posedge clk) cnt <= 4'hF;
    #1;
    cmp(of, 9'h000);
    @(posedge clk) cnt_stb <= 1'h0;
    step(3);
    cmp({of, scl_oe}, {7'h00, 1'h1, m[0]});
    @(posedge clk) clr_of <= 1'h1;
    @(posedge clk) clr_of <= 1'h0;
    step(3);
    cmp({of, scl_oe}, 9'h000);
    $display("t_ovf done");
  endtask
  // fill with reader stalled, then drain in order
  task t_buf;
    int acc;
    acc = 0;
    for (int i = 0; i < 4; i++) begin
      if (rx_rdy === 1'h1) begin
        @(posedge clk);
        sh <= 8'h10 + acc[7:0];
        push <= 1'h1;
        @(posedge clk) push <= 1'h0;
        acc++;
      end
      step(3);
    end
    cmp(acc, 9'h002);
    for (int i = 0; i < 2; i++) begin
      cmp({rx_v, rx_d}, {1'h1, 8'h10 + i[7:0]});
      @(posedge clk) take <= 1'h1;
      @(posedge clk) take <= 1'h0;
      step(2);
    end
    cmp(rx_v, 9'h000);
    $display("t_buf done");
  endtask
  initial begin
    step(3);
    @(posedge clk) rst_b <= 1'h1;
    step(2);
    t_off;
    t_3w;
    t_2w;
    t_ovf(2'h3);
    t_ovf(2'h2);
    t_buf;
    close_out;
  end
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out;
  end
endmodule // tb_top
bind usu_pins usu_chk u_chk (.clk, .rst_b, .do_dir_bit, .do_port_bit, .scl_dir_bit, .scl_port_bit,
  .cnt_wrap_stb, .cnt_value, .clr_start_flag, .do_oe, .do_pullup, .sda_pullup_off, .scl_pullup_off,
  .scl_oe, .start_condition_flag, .counter_overflow_flag, .mode_out);
